// File: pci_fifo_pkg.sv
// Purpose: shared types and constants for the PCI core FIFO block
// Assumes: one 20 MHz clock for bus and application sides
// Notes: FIFO index equals the fifo_sel_e code
package pci_fifo_pkg;

  // which of the four FIFOs the bus engine is working on
  typedef enum logic [1:0] {
    SEL_MW = 2'b00, // master write
    SEL_MR = 2'b01, // master read
    SEL_TW = 2'b10, // target write
    SEL_TR = 2'b11  // target read
  } fifo_sel_e;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_e;

  // one FIFO entry: 8 byte enables over 64 data bits
  typedef struct packed {
    logic [7:0] ben;
    logic [63:0] data;
  } fifo_word_s;

  // one 32-bit data phase waiting for its partner
  typedef struct packed {
    logic [3:0] ben;
    logic [31:0] data;
  } half_word_s;

  typedef struct packed {
    logic [29:0] rsvd;
    logic tgtUserClk;
    logic mstUserClk;
  } ctrl_s;

  localparam int NUM_FIFOS = 4;
  localparam int FIFO_DEPTH_N = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [4:0] FIFO_FULL_LVL = 5'h10;
  localparam logic [4:0] ALMOST_FULL_LVL = 5'h0C;
  localparam logic [4:0] ALMOST_EMPTY_LVL = 5'h04;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [3:0] PTR_ONE = 4'h1;
  // bit set where the application fills the FIFO (MW, TR)
  localparam logic [3:0] APP_WRITES = 4'h9;
  localparam logic [1:0] BURST_LINEAR = 2'h0;
  localparam logic [3:0] ALL_BYTES_L = 4'h0;

  // register offsets on APB
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] BUS_OFS = 8'h08;

endpackage

// File: pci_core_fifo_buffers.sv
// Purpose: four 72-bit FIFOs between PCI engine and application, with flags
// Assumes: PCI pins are on mclk domain but resynchronised by two flops
// Notes: bus-side FIFO choice comes from the core transaction controller
//
// Contract
// - four FIFOs: master and target, each direction
// - each entry is 64 data plus 8 enables
// - pack two 32-bit data phases per entry
// - full, empty, almost-full, almost-empty flags per FIFO
// - application gets its side's flag and almost flag
// - application also sees bus side full/empty
// - flag assignment per operation as tabled
// - application side timing selectable, master and target
// - PCI signals sampled on rising clock edge
// - PCI outputs released during PCI reset
// - address phase then one or more data phases
// - lowest lane is least significant byte
// - burst order 00 linear, others disconnect
// - command in address phase, enables after
// - byte enables valid for whole data phase
// - even parity over address/data and command lines
// - parity valid one clock after driven data
// - master parity on address/writes, target on reads
// - data phase done when both readies asserted
`timescale 1ns/100ps
`default_nettype none

module pci_core_fifo_buffers (
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PCI pins, input halves
  input wire logic pciRst_b,
  input wire logic [31:0] adIn,
  input wire logic [3:0] cbeIn_l,
  input wire logic parIn,
  input wire logic frameIn_l,
  input wire logic irdyIn_l,
  input wire logic trdyIn_l,
  // PCI pins, output halves
  output var logic [31:0] adOut,
  output var logic adOe,
  output var logic [3:0] cbeOut_l,
  output var logic cbeOe,
  output var logic parOut,
  output var logic parOe,
  // core transaction controller
  input wire pci_fifo_pkg::fifo_sel_e busSel,
  input wire logic mstAddrPhase,
  input wire logic [31:0] mstAddr,
  input wire logic [3:0] mstCmd_l,
  output var logic stopReq,
  // application side
  input wire logic mstUserEn,
  input wire logic tgtUserEn,
  input wire logic mwAppWrite,
  input wire pci_fifo_pkg::fifo_word_s mwAppData,
  input wire logic trAppWrite,
  input wire pci_fifo_pkg::fifo_word_s trAppData,
  input wire logic mrAppRead,
  output var pci_fifo_pkg::fifo_word_s mrAppData,
  input wire logic twAppRead,
  output var pci_fifo_pkg::fifo_word_s twAppData,
  // flags
  output logic mst_wr_app_full_l,
  output logic mst_wr_app_almost_full_l,
  output logic mst_wr_bus_empty_l,
  output logic mst_rd_app_empty_l,
  output logic mst_rd_app_almost_empty_l,
  output logic mst_rd_bus_full_l,
  output logic tgt_wr_app_empty_l,
  output logic tgt_wr_app_almost_empty_l,
  output logic tgt_wr_bus_full_l,
  output logic tgt_rd_app_full_l,
  output logic tgt_rd_app_almost_full_l,
  output logic tgt_rd_bus_empty_l
);
  import pci_fifo_pkg::*;

  // pin synchronisers: first stage read only by the second
  logic [31:0] adMeta_r, adS_r;
  logic [3:0] cbeMeta_r, cbeS_r;
  logic [4:0] ctlMeta_r, ctlS_r;
  logic parS, frameS_l, irdyS_l, trdyS_l, pciRstS_b;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      adMeta_r <= 32'h0;
      adS_r <= 32'h0;
      cbeMeta_r <= 4'hF;
      cbeS_r <= 4'hF;
      ctlMeta_r <= 5'h0E;
      ctlS_r <= 5'h0E;
    end else begin
      adMeta_r <= adIn;
      adS_r <= adMeta_r;
      cbeMeta_r <= cbeIn_l;
      cbeS_r <= cbeMeta_r;
      ctlMeta_r <= {pciRst_b, frameIn_l, irdyIn_l, trdyIn_l, parIn};
      ctlS_r <= ctlMeta_r;
    end
  end

  assign {pciRstS_b, frameS_l, irdyS_l, trdyS_l, parS} = ctlS_r;
  // PCI reset clears all engine state, not only the outputs
  logic coreRst;
  assign coreRst = !rst_b || !pciRstS_b;

  // registers
  ctrl_s ctrl_r;
  logic parErr_r;
  logic [3:0] cmd_r;
  logic [1:0] burst_r;
  logic [31:0] statusWord;

  // application side enables, per master and target group
  logic mstEn, tgtEn;
  assign mstEn = ctrl_r.mstUserClk ? mstUserEn : 1'b1;
  assign tgtEn = ctrl_r.tgtUserClk ? tgtUserEn : 1'b1;

  // bus transaction tracking
  bus_state_e busState_r;
  logic halfHi_r, dpSeen_r;
  half_word_s loHalf_r;
  logic addrPhase, dpDone, endTxn, popDir, busPush, busPop;

  assign addrPhase = (busState_r == BUS_IDLE) && !frameS_l;
  assign dpDone = (busState_r == BUS_DATA) && !irdyS_l && !trdyS_l;
  assign endTxn = (busState_r == BUS_DATA) && frameS_l && irdyS_l;
  assign popDir = APP_WRITES[busSel];
  assign busPop = popDir && dpDone && halfHi_r;
  assign busPush = !popDir && halfHi_r && (dpDone || endTxn);

  // per-FIFO request vectors, index is the fifo_sel_e code
  logic [3:0] push, pop, appWrReq, appRdReq, grpEn, fullF, emptyF, afF, aeF;
  fifo_word_s appWrData [NUM_FIFOS];
  fifo_word_s headWord [NUM_FIFOS];
  fifo_word_s rdData [NUM_FIFOS];
  fifo_word_s busWord;

  assign appWrReq = {trAppWrite, 1'b0, 1'b0, mwAppWrite};
  assign appRdReq = {1'b0, twAppRead, mrAppRead, 1'b0};
  assign grpEn = {tgtEn, tgtEn, mstEn, mstEn};
  assign appWrData[SEL_MW] = mwAppData;
  assign appWrData[SEL_MR] = '0;
  assign appWrData[SEL_TW] = '0;
  assign appWrData[SEL_TR] = trAppData;

  // second half present, or odd last phase padded with no bytes enabled
  assign busWord.ben = dpDone ? {~cbeS_r, loHalf_r.ben} : {4'h0, loHalf_r.ben};
  assign busWord.data = dpDone ? {adS_r, loHalf_r.data} : {32'h0, loHalf_r.data};

  // four independent FIFOs, each with its own memory
  genvar i;
  generate
    for (i = 0; i < NUM_FIFOS; i++) begin : g_fifo
      fifo_word_s mem [FIFO_DEPTH_N];
      logic [PTR_W-1:0] wp_r, rp_r;
      logic [CNT_W-1:0] cnt_r;
      logic doPush, doPop;

      assign push[i] = APP_WRITES[i] ? (appWrReq[i] && grpEn[i])
                                     : (busPush && (busSel == fifo_sel_e'(i)));
      assign pop[i] = APP_WRITES[i] ? (busPop && (busSel == fifo_sel_e'(i)))
                                    : (appRdReq[i] && grpEn[i]);
      assign fullF[i] = (cnt_r == FIFO_FULL_LVL);
      assign emptyF[i] = (cnt_r == 5'h00);
      assign afF[i] = (cnt_r >= ALMOST_FULL_LVL);
      assign aeF[i] = (cnt_r <= ALMOST_EMPTY_LVL);
      assign doPush = push[i] && !fullF[i];
      assign doPop = pop[i] && !emptyF[i];
      assign headWord[i] = mem[rp_r];
      assign statusWord[i*8 +: 8] = {3'h0, cnt_r};

      // memory carries no reset; pointers, count and read data do
      always_ff @(posedge mclk) begin
        if (doPush) begin
          mem[wp_r] <= APP_WRITES[i] ? appWrData[i] : busWord;
        end
      end

      // pointers and occupancy
      always_ff @(posedge mclk) begin
        if (coreRst) begin
          wp_r <= '0;
          rp_r <= '0;
          cnt_r <= '0;
          rdData[i] <= '0;
        end else begin
          if (doPush) wp_r <= wp_r + PTR_ONE;
          if (doPop) rp_r <= rp_r + PTR_ONE;
          if (doPop) rdData[i] <= mem[rp_r];
          if (doPush && !doPop) cnt_r <= cnt_r + CNT_ONE;
          else if (doPop && !doPush) cnt_r <= cnt_r - CNT_ONE;
        end
      end

      property p_no_overflow;
        @(posedge mclk) disable iff (coreRst)
        push[i] && fullF[i] && !pop[i] |=> (wp_r == $past(wp_r)) && fullF[i];
      endproperty
      a_no_overflow: assert property (p_no_overflow)
        else $error("write to full FIFO was not ignored");

      property p_no_underflow;
        @(posedge mclk) disable iff (coreRst)
        pop[i] && emptyF[i] && !push[i] |=> (rp_r == $past(rp_r)) && emptyF[i];
      endproperty
      a_no_underflow: assert property (p_no_underflow)
        else $error("read from empty FIFO was not ignored");

      property p_count_up;
        @(posedge mclk) disable iff (coreRst)
        push[i] && !pop[i] && (cnt_r == 5'h0B) |=> afF[i] && !fullF[i] ##1 !emptyF[i];
      endproperty
      a_count_up: assert property (p_count_up)
        else $error("almost full not reached at four short of full");
    end
  endgenerate

  assign mrAppData = rdData[SEL_MR];
  assign twAppData = rdData[SEL_TW];

  // flag map: application side first, then bus side
  assign mst_wr_app_full_l = !fullF[SEL_MW];
  assign mst_wr_app_almost_full_l = !afF[SEL_MW];
  assign mst_wr_bus_empty_l = !emptyF[SEL_MW];
  assign mst_rd_app_empty_l = !emptyF[SEL_MR];
  assign mst_rd_app_almost_empty_l = !aeF[SEL_MR];
  assign mst_rd_bus_full_l = !fullF[SEL_MR];
  assign tgt_wr_app_empty_l = !emptyF[SEL_TW];
  assign tgt_wr_app_almost_empty_l = !aeF[SEL_TW];
  assign tgt_wr_bus_full_l = !fullF[SEL_TW];
  assign tgt_rd_app_full_l = !fullF[SEL_TR];
  assign tgt_rd_app_almost_full_l = !afF[SEL_TR];
  assign tgt_rd_bus_empty_l = !emptyF[SEL_TR];

  // transaction state, packing half and captured address-phase fields
  always_ff @(posedge mclk) begin
    if (coreRst) begin
      busState_r <= BUS_IDLE;
      halfHi_r <= 1'b0;
      dpSeen_r <= 1'b0;
      loHalf_r <= '0;
      cmd_r <= 4'hF;
      burst_r <= BURST_LINEAR;
    end else begin
      case (busState_r)
        BUS_IDLE: begin
          if (addrPhase) begin
            busState_r <= BUS_DATA;
            cmd_r <= cbeS_r;
            burst_r <= adS_r[1:0];
            halfHi_r <= 1'b0;
            dpSeen_r <= 1'b0;
          end
        end
        BUS_DATA: begin
          if (endTxn) begin
            busState_r <= BUS_IDLE;
            halfHi_r <= 1'b0;
          end else if (dpDone) begin
            halfHi_r <= !halfHi_r;
            dpSeen_r <= 1'b1;
            if (!halfHi_r) loHalf_r <= '{ben: ~cbeS_r, data: adS_r};
          end
        end
        default: busState_r <= BUS_IDLE;
      endcase
    end
  end

  // non-linear burst order asks for disconnect after the first transfer
  assign stopReq = (busState_r == BUS_DATA) && dpSeen_r && (burst_r != BURST_LINEAR);

  // output drive; the lag of the synchronisers is the price of clean pins
  logic srcData, srcMst;
  half_word_s srcHalf;
  assign srcData = (busState_r == BUS_DATA) && popDir;
  assign srcMst = (busSel == SEL_MW) || (busSel == SEL_MR);
  assign srcHalf = halfHi_r ? '{ben: headWord[busSel].ben[7:4], data: headWord[busSel].data[63:32]}
                            : '{ben: headWord[busSel].ben[3:0], data: headWord[busSel].data[31:0]};

  always_ff @(posedge mclk) begin
    if (coreRst) begin
      adOut <= 32'h0;
      adOe <= 1'b0;
      cbeOut_l <= 4'hF;
      cbeOe <= 1'b0;
      parOut <= 1'b0;
      parOe <= 1'b0;
    end else begin
      if (mstAddrPhase) begin
        adOut <= mstAddr;
        cbeOut_l <= mstCmd_l;
      end else begin
        adOut <= srcHalf.data;
        cbeOut_l <= (busSel == SEL_MR) ? ALL_BYTES_L : ~srcHalf.ben;
      end
      adOe <= mstAddrPhase || srcData;
      cbeOe <= mstAddrPhase || ((busState_r == BUS_DATA) && srcMst);
      parOut <= ^{adOut, cbeOut_l};
      parOe <= adOe;
    end
  end

  // received parity, checked one clock after the data phase
  logic rxPar_r, rxChk_r, parBad;
  always_ff @(posedge mclk) begin
    if (coreRst) begin
      rxPar_r <= 1'b0;
      rxChk_r <= 1'b0;
    end else begin
      rxPar_r <= ^{adS_r, cbeS_r};
      rxChk_r <= dpDone && !popDir;
    end
  end
  assign parBad = rxChk_r && (parS != rxPar_r);

  // APB slave: zero wait states, read data latched in the setup cycle
  logic setup, access, wrAccess, mapped, hitCtrl, hitBus;
  logic [31:0] rdMux;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hitCtrl = (paddr == CTRL_OFS);
  assign hitBus = (paddr == BUS_OFS);
  assign mapped = hitCtrl || hitBus || (paddr == STATUS_OFS);
  assign wrAccess = access && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign rdMux = hitCtrl ? 32'(ctrl_r)
               : hitBus ? {22'h0, burst_r, cmd_r, 3'h0, parErr_r}
               : (paddr == STATUS_OFS) ? statusWord : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_r <= '0;
      prdata <= 32'h0;
      parErr_r <= 1'b0;
    end else begin
      if (setup && !pwrite) prdata <= rdMux;
      if (wrAccess && hitCtrl) ctrl_r <= ctrl_s'({30'h0, pwdata[1:0]});
      // a new error in the clearing cycle is kept
      if (parBad) parErr_r <= 1'b1;
      else if (wrAccess && hitBus && pwdata[0]) parErr_r <= 1'b0;
    end
  end

  property p_reset_release;
    @(posedge mclk) !pciRstS_b |=> !adOe && !cbeOe && !parOe;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("PCI outputs driven during PCI reset");

  property p_par_follow;
    @(posedge mclk) disable iff (coreRst)
    adOe ##1 !coreRst |-> parOe && (parOut == ^{$past(adOut), $past(cbeOut_l)});
  endproperty
  a_par_follow: assert property (p_par_follow)
    else $error("parity not valid one clock after driven data");

  property p_dp_pack;
    @(posedge mclk) disable iff (coreRst)
    dpDone && !halfHi_r |-> !busPush && !busPop ##1 halfHi_r;
  endproperty
  a_dp_pack: assert property (p_dp_pack)
    else $error("first data phase did not wait for its partner");

  property p_stop_burst;
    @(posedge mclk) disable iff (coreRst)
    dpDone && (burst_r != BURST_LINEAR) |=> stopReq;
  endproperty
  a_stop_burst: assert property (p_stop_burst)
    else $error("no disconnect after first transfer");

  property p_user_clk;
    @(posedge mclk) disable iff (coreRst)
    ctrl_r.mstUserClk && !mstUserEn |-> !push[SEL_MW] && !pop[SEL_MR];
  endproperty
  a_user_clk: assert property (p_user_clk)
    else $error("master application side moved without its enable");

  property p_cmd_capture;
    @(posedge mclk) disable iff (coreRst)
    addrPhase |=> (cmd_r == $past(cbeS_r)) && (busState_r == BUS_DATA);
  endproperty
  a_cmd_capture: assert property (p_cmd_capture)
    else $error("address phase command not captured");

endmodule

`default_nettype wire

// File: pci_agent_model.sv
// Purpose: far-side PCI agent that runs write bursts into the core
// Assumes: pins change just after a rising edge and hold for the whole cycle
// Notes: released data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none

module pci_agent_model (
  input wire logic mclk,
  output logic [31:0] agentAd,
  output logic [3:0] agentCbe_l,
  output logic agentPar,
  output logic frame_l,
  output logic irdy_l,
  output logic trdy_l
);
  logic badPar;

  // idle bus, control lines at their pulled-up level
  initial begin
    agentAd = 32'h0;
    agentCbe_l = 4'hF;
    agentPar = 1'b0;
    frame_l = 1'b1;
    irdy_l = 1'b1;
    trdy_l = 1'b1;
    badPar = 1'b0;
  end

  // even parity one clock behind the phase it
  always @(posedge mclk) begin
    agentPar <= ^{agentAd, agentCbe_l} ^ badPar;
  end

  function automatic logic [31:0] patData(input int i);
    return {i[7:0], 8'hA5, ~i[7:0], 8'h3C};
  endfunction

  // one address phase, then n data phases; waits stalls target ready
  task automatic burst(input logic [31:0] addr, input logic [3:0] cmd, input int n,
      input int waits, input logic bad);
    int i;
    @(posedge mclk);
    frame_l <= 1'b0;
    agentAd <= addr;
    agentCbe_l <= cmd;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      frame_l <= (i == n - 1);
      irdy_l <= 1'b0;
      trdy_l <= (waits > 0);
      agentAd <= patData(i);
      agentCbe_l <= i[3:0];
      badPar <= bad && (i == 0);
      if (waits > 0) begin
        repeat (waits) @(posedge mclk);
        trdy_l <= 1'b0;
      end
    end
    @(posedge mclk);
    frame_l <= 1'b1;
    irdy_l <= 1'b1;
    trdy_l <= 1'b1;
    badPar <= 1'b0;
    agentAd <= ~agentAd;
    agentCbe_l <= ~agentCbe_l;
  endtask
endmodule

`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the four-FIFO PCI block
// Assumes: one 20 MHz clock, far side played by pci_agent_model
// Notes: register cases run from a table, FIFO and bus cases by hand
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import pci_fifo_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
  } row_s;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, pciRst_b, parIn, parOut;
  logic adOe, cbeOe, parOe, mstAddrPhase, stopReq, mstUserEn, tgtUserEn, err, agentPar;
  logic mwAppWrite, trAppWrite, mrAppRead, twAppRead, frameIn_l, irdyIn_l, trdyIn_l;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, adIn, adOut, mstAddr, agentAd, rd;
  logic [3:0] cbeIn_l, cbeOut_l, mstCmd_l, agentCbe_l;
  logic mst_wr_app_full_l, mst_wr_app_almost_full_l, mst_wr_bus_empty_l, mst_rd_app_empty_l;
  logic mst_rd_app_almost_empty_l, mst_rd_bus_full_l, tgt_wr_app_empty_l, tgt_rd_bus_empty_l;
  logic tgt_wr_app_almost_empty_l, tgt_wr_bus_full_l, tgt_rd_app_full_l, tgt_rd_app_almost_full_l;
  logic [11:0] flags;
  fifo_sel_e busSel;
  fifo_word_s mwAppData, trAppData, mrAppData, twAppData;
  int fail_count = 0;
  int num_checks = 0;
  int k, c;
  row_s rows [7];

  always #25 mclk = ~mclk;

  // line level: whoever holds the enable drives the wire
  assign adIn = adOe ? adOut : agentAd;
  assign cbeIn_l = cbeOe ? cbeOut_l : agentCbe_l;
  assign parIn = parOe ? parOut : agentPar;
  assign flags = {mst_wr_app_full_l, mst_wr_app_almost_full_l, mst_wr_bus_empty_l,
    mst_rd_app_empty_l, mst_rd_app_almost_empty_l, mst_rd_bus_full_l, tgt_wr_app_empty_l,
    tgt_wr_app_almost_empty_l, tgt_wr_bus_full_l, tgt_rd_app_full_l, tgt_rd_app_almost_full_l,
    tgt_rd_bus_empty_l};

  pci_core_fifo_buffers dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pciRst_b, .adIn, .cbeIn_l, .parIn, .frameIn_l, .irdyIn_l,
    .trdyIn_l, .adOut, .adOe, .cbeOut_l, .cbeOe, .parOut, .parOe, .busSel, .mstAddrPhase,
    .mstAddr, .mstCmd_l, .stopReq, .mstUserEn, .tgtUserEn, .mwAppWrite, .mwAppData,
    .trAppWrite, .trAppData, .mrAppRead, .mrAppData, .twAppRead, .twAppData,
    .mst_wr_app_full_l, .mst_wr_app_almost_full_l, .mst_wr_bus_empty_l, .mst_rd_app_empty_l,
    .mst_rd_app_almost_empty_l, .mst_rd_bus_full_l, .tgt_wr_app_empty_l,
    .tgt_wr_app_almost_empty_l, .tgt_wr_bus_full_l, .tgt_rd_app_full_l,
    .tgt_rd_app_almost_full_l, .tgt_rd_bus_empty_l);

  pci_agent_model agent (.mclk, .agentAd, .agentCbe_l, .agentPar, .frame_l(frameIn_l),
    .irdy_l(irdyIn_l), .trdy_l(trdyIn_l));

  task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // stored entry j packs dwords 2j and 2j+1, low dword in the low half
  function automatic logic [71:0] entry(input int j);
    return {~4'(2 * j + 1), ~4'(2 * j), agent.patData(2 * j + 1), agent.patData(2 * j)};
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog sized well past the roughly 170 cycles the run needs
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    $display("FAIL watchdog expected end seen hang");
    print_verdict();
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pciRst_b = 1'b1;
    busSel = SEL_MW;
    mstAddrPhase = 1'b0;
    mstAddr = 32'h0;
    mstCmd_l = 4'hF;
    mstUserEn = 1'b0;
    tgtUserEn = 1'b0;
    mwAppWrite = 1'b0;
    trAppWrite = 1'b0;
    mrAppRead = 1'b0;
    twAppRead = 1'b0;
    mwAppData = '0;
    trAppData = '0;
    rows[0] = '{1'b0, CTRL_OFS, 32'h0, 32'h0, 1'b0};
    rows[1] = '{1'b1, CTRL_OFS, 32'h3, 32'h0, 1'b0};
    rows[2] = '{1'b0, CTRL_OFS, 32'h0, 32'h3, 1'b0};
    rows[3] = '{1'b0, STATUS_OFS, 32'h0, 32'h0, 1'b0};
    rows[4] = '{1'b0, BUS_OFS, 32'h0, 32'hF0, 1'b0};
    rows[5] = '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1};
    rows[6] = '{1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'b1};
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chk("reset flags", 12'hC4E, flags);
    chk("reset enables", 3'h0, {adOe, cbeOe, parOe});
    @(posedge mclk);
    rst_b <= 1'b1;
    for (k = 0; k < 7; k++) begin
      apb(rows[k].w, rows[k].a, rows[k].d, rd, err);
      chk("pslverr", rows[k].e, err);
      if (!rows[k].w) chk("prdata", rows[k].r, rd);
    end
    // user timing selected, enables low: pushes must not land
    @(posedge mclk);
    mwAppWrite <= 1'b1;
    trAppWrite <= 1'b1;
    @(posedge mclk);
    mwAppWrite <= 1'b0;
    trAppWrite <= 1'b0;
    mstUserEn <= 1'b1;
    tgtUserEn <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    chk("gated count", 32'h0, rd);
    // fill both application-written FIFOs past full
    for (k = 1; k <= 18; k++) begin
      @(posedge mclk);
      mwAppWrite <= (k < 18);
      trAppWrite <= (k < 18);
      mwAppData <= {8'hFF, 32'h0, k};
      trAppData <= {8'h0F, 32'h1, k};
      @(negedge mclk);
      c = (k > 17) ? 16 : k - 1;
      chk("fill flags", {2{c != 16, c < 12, c != 0}}, {flags[11:9], flags[2:0]});
    end
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    chk("full count", 32'h1000_0010, rd);
    // master address phase onto the pins
    busSel <= SEL_MW;
    mstAddrPhase <= 1'b1;
    mstAddr <= 32'h0000_1230;
    mstCmd_l <= 4'h7;
    @(posedge mclk);
    mstAddrPhase <= 1'b0;
    // enables are looked at mid-cycle, never in the edge that launches them
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (adOe !== 1'b1 && k < 10);
    chk("addr phase", {1'b1, 4'h7, 32'h0000_1230}, {cbeOe, cbeOut_l, adOut});
    @(negedge mclk);
    chk("addr parity", {1'b1, ^{32'h0000_1230, 4'h7}}, {parOe, parOut});
    @(posedge mclk);
    pciRst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("pci reset enables", 3'h0, {adOe, cbeOe, parOe});
    @(posedge mclk);
    pciRst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    chk("pci reset count", 32'h0, rd);
    chk("pci reset flags", 12'hC4E, flags);
    // target write burst of 34 dwords: 17 entries offered, 16 fit
    busSel <= SEL_TW;
    agent.burst(32'h0000_4000, 4'h7, 34, 0, 1'b0);
    repeat (6) @(posedge mclk);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    chk("tw count", 32'h0010_0000, rd);
    apb(1'b0, BUS_OFS, 32'h0, rd, err);
    chk("bus reg", 32'h70, rd);
    for (k = 0; k <= 17; k++) begin
      @(posedge mclk);
      twAppRead <= (k < 17);
      @(negedge mclk);
      c = (k > 16) ? 0 : 16 - k;
      chk("drain flags", {c != 0, c > 4, c != 16}, flags[5:3]);
      if (k > 0) chk("tw entry", entry((k > 16) ? 15 : k - 1), twAppData);
    end
    // slow single-dword burst with bad data parity, non-linear order
    agent.burst(32'h0000_5001, 4'hF, 1, 2, 1'b1);
    repeat (6) @(posedge mclk);
    apb(1'b0, BUS_OFS, 32'h0, rd, err);
    chk("parity error", 32'h1F1, rd);
    apb(1'b1, BUS_OFS, 32'h1, rd, err);
    apb(1'b0, BUS_OFS, 32'h0, rd, err);
    chk("parity cleared", 32'h1F0, rd);
    @(posedge mclk);
    twAppRead <= 1'b1;
    @(posedge mclk);
    twAppRead <= 1'b0;
    @(negedge mclk);
    chk("odd entry", {8'h0F, 32'h0, agent.patData(0)}, twAppData);
    // master read path: two received dwords make one application entry
    @(posedge mclk);
    busSel <= SEL_MR;
    agent.burst(32'h0000_6000, 4'h6, 2, 0, 1'b0);
    repeat (6) @(posedge mclk);
    mrAppRead <= 1'b1;
    @(negedge mclk);
    chk("mr flags", 3'b101, flags[8:6]);
    @(posedge mclk);
    mrAppRead <= 1'b0;
    @(negedge mclk);
    chk("mr entry", entry(0), mrAppData);
    chk("mr drained flags", 3'b001, flags[8:6]);
    print_verdict();
  end
endmodule

`default_nettype wire
